//--- inc/mdfp_regs.svh
// constants for the motor driver fault protection block
`ifndef MDFP_REGS_SVH
`define MDFP_REGS_SVH
`define MDFP_NUM_FET 6
`define MDFP_NUM_LOCK 3
`define MDFP_NUM_SRC 3
`define MDFP_SRC_OC 0
`define MDFP_SRC_IL 1
`define MDFP_SRC_LK 2
`define MDFP_LIM_HIGH_BIT 3
`define MDFP_LIM_RETRY_BIT 2
`define MDFP_LIM_OFF_BIT 0
`define MDFP_STICKY_RST 1'b0
`define MDFP_DEG_WIDTH 8
`define MDFP_RETRY_WIDTH 16
`endif

//--- inc/mdfp_pkg.sv
// types shared by the fault protection block
package mdfp_pkg;
`include "mdfp_regs.svh"
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LATCH = 4'h2,
    ST_RETRY = 4'h4,
    ST_REPORT = 4'h8
  } mdfp_state_e;
  // overcurrent response codes map straight onto this order
  typedef enum logic [1:0] {
    ACT_LATCH = 2'h0,
    ACT_RETRY = 2'h1,
    ACT_REPORT = 2'h2,
    ACT_NONE = 2'h3
  } mdfp_act_e;
  typedef enum logic [2:0] {
    BR_NORMAL = 3'h0,
    BR_ALL_OFF = 3'h1,
    BR_RECIRC = 3'h2,
    BR_HS_ON = 3'h3,
    BR_LS_ON = 3'h4
  } mdfp_bridge_e;
  typedef struct packed {
    logic driver_fault;
    logic controller_fault;
    logic fet_overcurrent_flag;
    logic [`MDFP_NUM_FET-1:0] fet_flag;
    logic current_limit_flag;
    logic motor_lock_flag;
    logic [`MDFP_NUM_LOCK-1:0] lock_cond_flag;
    logic die_heat_flag;
    logic heat_warning_flag;
    logic thermal_shutdown_flag;
  } mdfp_flags_s;
endpackage

//--- design/mdfp_deglitch.sv
// deglitch counter: detect a condition held longer than a set count
`timescale 1ns/1ps
module mdfp_deglitch #(
  parameter int DW = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // condition and its deglitch count
  input wire logic i_cond,
  input wire logic [DW-1:0] i_deg,
  // qualified detection
  output logic o_det
);
  logic [DW:0] cnt;
  wire logic longer = (cnt > {1'b0, i_deg});
  // saturating count, restarts as soon as the condition drops
  always_ff @(posedge i_clk) begin
    if (!i_nrst || !i_cond) begin
      cnt <= '0;
    end else if (!longer) begin
      cnt <= cnt + 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_det <= 1'b0;
    end else begin
      o_det <= i_cond && longer;
    end
  end
  a_deg_qualified: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_det) |-> $past(i_cond) && $past(cnt) > {1'b0, $past(i_deg)})
    else $error("deglitch fired before count elapsed");
endmodule

//--- design/mdfp_top.sv
// fault supervision and response for a three-phase motor driver
// Contract
// - fet overcurrent counts only when held above threshold past its deglitch
// - overcurrent latched: all fets off, pin low, flags, release on clear
// - overcurrent retry: all fets off, pin low, resume after retry time
// - retry end clears driver fault; overcurrent flags stay until clear
// - overcurrent report only: keep driving, set flags, clear on clear
// - overcurrent disabled: no action at all
// - buck overcurrent past deglitch: buck switches hi-z and reset state
// - current limit past deglitch responds by its four-bit field
// - limit 00xx: chosen fet state, pin low, flags, release on clear
// - limit 01xx: same state, resume and clear flags after lock retry
// - limit 1000: keep driving, report flags, clear on clear
// - limit 1xx1: no action
// - heat warning reporting pulls pin low until cooled below hysteresis
// - heat warning flag held until clear while cooled
// - shutdown: fets off, charge pump off, pin low, resume when cooled
// - shutdown flag latched until clear, protection cannot be disabled
// - any enabled lock condition while running raises motor lock event
// - lock 00xx: chosen fet state, pin low, flags, release on clear
// - lock 01xx: chosen state, pin low, resume and clear after retry
// - lock 1000 report only until clear; 1xx1 takes no action
`timescale 1ns/1ps
`include "mdfp_regs.svh"
module mdfp_top #(
  parameter int DW = `MDFP_DEG_WIDTH,
  parameter int RW = `MDFP_RETRY_WIDTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // sensed conditions
  input wire logic [`MDFP_NUM_FET-1:0] i_fet_oc,
  input wire logic i_buck_oc,
  input wire logic i_current_sense_amp_over,
  input wire logic i_die_warn_hot,
  input wire logic i_die_warn_cool,
  input wire logic i_die_tsd_hot,
  input wire logic i_die_tsd_cool,
  input wire logic i_motor_running,
  input wire logic [`MDFP_NUM_LOCK-1:0] i_lock_cond,
  // configuration
  input wire logic [1:0] i_fet_overcurrent_response_select,
  input wire logic [DW-1:0] i_fet_overcurrent_deglitch,
  input wire logic [RW-1:0] i_overcurrent_retry_time,
  input wire logic [3:0] i_current_limit_response_select,
  input wire logic [DW-1:0] i_current_limit_deglitch,
  input wire logic [RW-1:0] i_lock_retry_time,
  input wire logic i_heat_warning_report_enable,
  input wire logic [3:0] i_motor_lock_response_select,
  input wire logic [`MDFP_NUM_LOCK-1:0] i_lock_en,
  input wire logic i_clear_fault_bit,
  // responses and status
  output logic o_fault_pin_n,
  output mdfp_pkg::mdfp_bridge_e o_bridge,
  output logic o_charge_pump_en,
  output logic o_buck_hiz,
  output logic o_reset_req,
  output mdfp_pkg::mdfp_flags_s o_flags
);
  if (DW < 1 || RW < 1) begin : g_chk
    $error("mdfp_top: counter widths must be at least one bit");
  end

  // limit and lock share one code layout
  function automatic mdfp_pkg::mdfp_act_e code_act(input logic [3:0] code);
    if (!code[`MDFP_LIM_HIGH_BIT]) begin
      return code[`MDFP_LIM_RETRY_BIT] ? mdfp_pkg::ACT_RETRY : mdfp_pkg::ACT_LATCH;
    end
    // undefined high codes fall into report only
    return code[`MDFP_LIM_OFF_BIT] ? mdfp_pkg::ACT_NONE : mdfp_pkg::ACT_REPORT;
  endfunction

  function automatic mdfp_pkg::mdfp_bridge_e code_bridge(input logic [3:0] code);
    unique case (code[1:0])
      2'h0: return mdfp_pkg::BR_ALL_OFF;
      2'h1: return mdfp_pkg::BR_RECIRC;
      2'h2: return mdfp_pkg::BR_HS_ON;
      2'h3: return mdfp_pkg::BR_LS_ON;
    endcase
  endfunction

  // detection
  logic [`MDFP_NUM_FET-1:0] fet_det;
  logic il_det;
  logic buck_det;
  logic lk_det;
  for (genvar f = 0; f < `MDFP_NUM_FET; f++) begin : g_fet
    mdfp_deglitch #(.DW(DW)) u_deg (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_cond(i_fet_oc[f]),
      .i_deg(i_fet_overcurrent_deglitch),
      .o_det(fet_det[f])
    );
  end
  mdfp_deglitch #(.DW(DW)) u_il_deg (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cond(i_current_sense_amp_over),
    .i_deg(i_current_limit_deglitch),
    .o_det(il_det)
  );
  // buck shares the fet overcurrent deglitch time
  mdfp_deglitch #(.DW(DW)) u_buck_deg (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cond(i_buck_oc),
    .i_deg(i_fet_overcurrent_deglitch),
    .o_det(buck_det)
  );
  wire logic lk_hit = i_motor_running && |(i_lock_cond & i_lock_en);
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      lk_det <= 1'b0;
    end else begin
      lk_det <= lk_hit;
    end
  end

  // per source response machines: overcurrent, limit, lock
  mdfp_pkg::mdfp_act_e act [`MDFP_NUM_SRC];
  logic det [`MDFP_NUM_SRC];
  logic [RW-1:0] rtime [`MDFP_NUM_SRC];
  mdfp_pkg::mdfp_bridge_e want [`MDFP_NUM_SRC];
  mdfp_pkg::mdfp_state_e st_v [`MDFP_NUM_SRC];
  logic enter [`MDFP_NUM_SRC];
  logic prot [`MDFP_NUM_SRC];
  logic busy [`MDFP_NUM_SRC];
  mdfp_pkg::mdfp_bridge_e sel [`MDFP_NUM_SRC];

  assign act[`MDFP_SRC_OC] = mdfp_pkg::mdfp_act_e'(i_fet_overcurrent_response_select);
  assign act[`MDFP_SRC_IL] = code_act(i_current_limit_response_select);
  assign act[`MDFP_SRC_LK] = code_act(i_motor_lock_response_select);
  assign det[`MDFP_SRC_OC] = |fet_det;
  assign det[`MDFP_SRC_IL] = il_det;
  assign det[`MDFP_SRC_LK] = lk_det;
  assign rtime[`MDFP_SRC_OC] = i_overcurrent_retry_time;
  assign rtime[`MDFP_SRC_IL] = i_lock_retry_time;
  assign rtime[`MDFP_SRC_LK] = i_lock_retry_time;
  assign want[`MDFP_SRC_OC] = mdfp_pkg::BR_ALL_OFF;
  assign want[`MDFP_SRC_IL] = code_bridge(i_current_limit_response_select);
  assign want[`MDFP_SRC_LK] = code_bridge(i_motor_lock_response_select);

  for (genvar s = 0; s < `MDFP_NUM_SRC; s++) begin : g_src
    mdfp_pkg::mdfp_state_e st;
    mdfp_pkg::mdfp_state_e next_st;
    logic [RW-1:0] rcnt;
    wire logic retry_done = (rcnt >= rtime[s]);
    // release needs the condition gone and the clear bit together
    wire logic release_ok = !det[s] && i_clear_fault_bit;
    always_comb begin
      next_st = st;
      unique case (st)
        mdfp_pkg::ST_IDLE: begin
          if (det[s]) begin
            unique case (act[s])
              mdfp_pkg::ACT_LATCH: next_st = mdfp_pkg::ST_LATCH;
              mdfp_pkg::ACT_RETRY: next_st = mdfp_pkg::ST_RETRY;
              mdfp_pkg::ACT_REPORT: next_st = mdfp_pkg::ST_REPORT;
              mdfp_pkg::ACT_NONE: next_st = mdfp_pkg::ST_IDLE;
            endcase
          end
        end
        mdfp_pkg::ST_LATCH, mdfp_pkg::ST_REPORT: begin
          if (release_ok) begin
            next_st = mdfp_pkg::ST_IDLE;
          end
        end
        mdfp_pkg::ST_RETRY: begin
          if (retry_done) begin
            next_st = mdfp_pkg::ST_IDLE;
          end
        end
        default: next_st = mdfp_pkg::ST_IDLE;
      endcase
    end
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        st <= mdfp_pkg::ST_IDLE;
      end else begin
        st <= next_st;
      end
    end
    // retry time counted in clock cycles from entry
    always_ff @(posedge i_clk) begin
      if (!i_nrst || st != mdfp_pkg::ST_RETRY) begin
        rcnt <= '0;
      end else if (!retry_done) begin
        rcnt <= rcnt + 1'b1;
      end
    end
    // bridge state frozen at entry so a code change mid fault is harmless
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        sel[s] <= mdfp_pkg::BR_ALL_OFF;
      end else if (enter[s]) begin
        sel[s] <= want[s];
      end
    end
    assign st_v[s] = st;
    assign enter[s] = (st == mdfp_pkg::ST_IDLE) && (next_st != mdfp_pkg::ST_IDLE);
    assign prot[s] = (st == mdfp_pkg::ST_LATCH) || (st == mdfp_pkg::ST_RETRY);
    assign busy[s] = (st != mdfp_pkg::ST_IDLE);
  end

  // thermal warning and shutdown
  logic warn_active;
  logic tsd_active;
  logic warn_flag;
  logic tsd_flag;
  wire logic warn_set = i_heat_warning_report_enable && i_die_warn_hot;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      warn_active <= 1'b0;
      tsd_active <= 1'b0;
    end else begin
      warn_active <= warn_set || (warn_active && !i_die_warn_cool);
      tsd_active <= i_die_tsd_hot || (tsd_active && !i_die_tsd_cool);
    end
  end
  // sticky flags: a new event in the clear cycle wins
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      warn_flag <= `MDFP_STICKY_RST;
      tsd_flag <= `MDFP_STICKY_RST;
    end else begin
      warn_flag <= warn_set || (warn_flag && !(i_clear_fault_bit && i_die_warn_cool));
      tsd_flag <= i_die_tsd_hot || (tsd_flag && !i_clear_fault_bit);
    end
  end

  // overcurrent and lock condition flags
  logic oc_flag;
  logic [`MDFP_NUM_FET-1:0] fet_flag;
  logic [`MDFP_NUM_LOCK-1:0] lock_flag;
  wire logic oc_catch = enter[`MDFP_SRC_OC] || busy[`MDFP_SRC_OC];
  wire logic oc_clr = i_clear_fault_bit && !det[`MDFP_SRC_OC];
  wire logic lk_catch = enter[`MDFP_SRC_LK] || busy[`MDFP_SRC_LK];
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      oc_flag <= `MDFP_STICKY_RST;
      fet_flag <= '0;
      lock_flag <= '0;
    end else begin
      oc_flag <= enter[`MDFP_SRC_OC] || (oc_flag && !oc_clr);
      fet_flag <= (oc_catch ? fet_det : '0) | (oc_clr ? '0 : fet_flag);
      lock_flag <= lk_catch ? (lock_flag | (i_lock_cond & i_lock_en)) : '0;
    end
  end

  // buck trip holds until the device reset it requests takes effect
  logic buck_trip;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      buck_trip <= 1'b0;
    end else begin
      buck_trip <= buck_trip || buck_det;
    end
  end

  // outputs, decoded from flip-flops only
  wire logic all_off = tsd_active || buck_trip || prot[`MDFP_SRC_OC];
  assign o_bridge = all_off ? mdfp_pkg::BR_ALL_OFF :
    prot[`MDFP_SRC_IL] ? sel[`MDFP_SRC_IL] :
    prot[`MDFP_SRC_LK] ? sel[`MDFP_SRC_LK] : mdfp_pkg::BR_NORMAL;
  assign o_fault_pin_n = !(prot[`MDFP_SRC_OC] || prot[`MDFP_SRC_IL] || prot[`MDFP_SRC_LK]
    || warn_active || tsd_active);
  assign o_charge_pump_en = !tsd_active;
  assign o_buck_hiz = buck_trip;
  assign o_reset_req = buck_trip;
  always_comb begin
    o_flags = '0;
    o_flags.driver_fault = busy[`MDFP_SRC_OC] || tsd_active;
    o_flags.controller_fault = busy[`MDFP_SRC_IL] || busy[`MDFP_SRC_LK];
    o_flags.fet_overcurrent_flag = oc_flag;
    o_flags.fet_flag = fet_flag;
    o_flags.current_limit_flag = busy[`MDFP_SRC_IL];
    o_flags.motor_lock_flag = busy[`MDFP_SRC_LK];
    o_flags.lock_cond_flag = lock_flag;
    o_flags.die_heat_flag = warn_active || tsd_active;
    o_flags.heat_warning_flag = warn_flag;
    o_flags.thermal_shutdown_flag = tsd_flag;
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire logic oc_latch = (st_v[`MDFP_SRC_OC] == mdfp_pkg::ST_LATCH);
  wire logic oc_retry = (st_v[`MDFP_SRC_OC] == mdfp_pkg::ST_RETRY);
  wire logic oc_report = (st_v[`MDFP_SRC_OC] == mdfp_pkg::ST_REPORT);
  wire logic il_retry = (st_v[`MDFP_SRC_IL] == mdfp_pkg::ST_RETRY);
  a_oc_latch_off: assert property (oc_latch |->
    o_bridge == mdfp_pkg::BR_ALL_OFF && !o_fault_pin_n && o_flags.driver_fault && oc_flag)
    else $error("latched overcurrent not forcing fets off");
  a_oc_latch_hold: assert property (oc_latch && !(!det[0] && i_clear_fault_bit)
    |=> oc_latch)
    else $error("latched overcurrent released without clear");
  a_oc_retry_end: assert property ($fell(oc_retry) && !$past(i_clear_fault_bit)
    && !tsd_active |-> !o_flags.driver_fault && o_flags.fet_overcurrent_flag && o_fault_pin_n
    || prot[1] || prot[2] || warn_active)
    else $error("retry end flags wrong");
  a_oc_retry_pin: assert property ($rose(oc_retry) |-> !o_fault_pin_n [*2])
    else $error("retry did not hold fault pin low");
  a_oc_report_run: assert property (oc_report && !all_off && !prot[1] && !prot[2]
    |-> o_bridge == mdfp_pkg::BR_NORMAL)
    else $error("report only overcurrent stopped the bridge");
  a_oc_disabled: assert property (act[0] == mdfp_pkg::ACT_NONE && !busy[0]
    |=> !busy[0])
    else $error("disabled overcurrent took action");
  a_il_retry_clear: assert property ($fell(il_retry) && !busy[2]
    |-> !o_flags.controller_fault && !o_flags.current_limit_flag)
    else $error("limit retry end did not clear flags");
  a_tsd_off: assert property ($rose(tsd_active) |-> o_bridge == mdfp_pkg::BR_ALL_OFF
    && !o_charge_pump_en && !o_fault_pin_n && $past(i_die_tsd_hot))
    else $error("shutdown response incomplete");
  a_tsd_flag_hold: assert property (tsd_flag && !i_clear_fault_bit |=> tsd_flag)
    else $error("shutdown flag dropped without clear");
  a_warn_pin: assert property (warn_set |=> !o_fault_pin_n && o_flags.heat_warning_flag)
    else $error("heat warning not reported");
  a_buck_trip: assert property ($rose(buck_det) |=> o_buck_hiz && o_reset_req)
    else $error("buck overcurrent not acted on");
  c_oc_latch: cover property (oc_latch ##[1:20] !busy[0]);
  c_il_retry: cover property ($rose(il_retry) ##[1:50] $fell(il_retry));
  c_lk_report: cover property (st_v[2] == mdfp_pkg::ST_REPORT);
  c_tsd: cover property ($rose(tsd_active) ##[1:50] $fell(tsd_active));
endmodule

//--- tb/mdfp_host_model.sv
// host controller model: writes the clear-fault bit when the bench asks
`timescale 1ns/1ps
module mdfp_host_model (
  // clock
  input wire logic i_clk,
  // request from the bench and host reaction delay in cycles
  input wire logic i_req,
  input wire logic [3:0] i_delay,
  // clear-fault bit to the device and completion to the bench
  output logic o_clear_fault_bit,
  output logic o_done
);
  int unsigned cnt;
  initial begin
    o_clear_fault_bit = 1'b0;
    o_done = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_req && !o_done) begin
        // a slow host waits before it writes; the bench decides when to ask
        for (cnt = 0; cnt < i_delay; cnt++) begin
          @(posedge i_clk);
        end
        #1;
        o_clear_fault_bit = 1'b1;
        @(posedge i_clk);
        // done settles on the edge so the bench never races the strobe update
        o_done <= 1'b1;
        #1;
        o_clear_fault_bit = 1'b0;
      end else if (!i_req) begin
        o_done <= 1'b0;
      end
    end
  end
endmodule

//--- tb/testbench.sv
// self-checking bench for the fault protection block
`timescale 1ns/1ps
module testbench;
  // short counts keep the run brief; all expectations derive from them
  localparam int DEG = 2;
  localparam int ORT = 6;
  localparam int LRT = 20;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [5:0] fet_oc = 6'h00;
  logic buck_oc = 1'b0;
  logic amp_over = 1'b0;
  logic warn_hot = 1'b0;
  logic warn_cool = 1'b1;
  logic tsd_hot = 1'b0;
  logic tsd_cool = 1'b1;
  logic running = 1'b1;
  logic [2:0] lock_c = 3'h0;
  logic [2:0] lock_en = 3'h7;
  logic [1:0] oc_sel = 2'h0;
  logic [3:0] lim_sel = 4'h0;
  logic [3:0] lck_sel = 4'h0;
  logic warn_rep = 1'b1;
  logic clr_req = 1'b0;
  logic [3:0] host_dly = 4'h0;
  logic clr;
  logic clr_done;
  logic pin_n, cp_en, buck_hiz, rst_req;
  mdfp_pkg::mdfp_bridge_e bridge;
  mdfp_pkg::mdfp_flags_s flags;
  mdfp_pkg::mdfp_flags_s exp_fl;
  int num_errors = 0;
  int num_checks = 0;

  always #5 i_clk = ~i_clk;

  mdfp_top i_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_fet_oc(fet_oc), .i_buck_oc(buck_oc),
    .i_current_sense_amp_over(amp_over), .i_die_warn_hot(warn_hot),
    .i_die_warn_cool(warn_cool), .i_die_tsd_hot(tsd_hot), .i_die_tsd_cool(tsd_cool),
    .i_motor_running(running), .i_lock_cond(lock_c),
    .i_fet_overcurrent_response_select(oc_sel), .i_fet_overcurrent_deglitch(8'(DEG)),
    .i_overcurrent_retry_time(16'(ORT)), .i_current_limit_response_select(lim_sel),
    .i_current_limit_deglitch(8'(DEG)), .i_lock_retry_time(16'(LRT)),
    .i_heat_warning_report_enable(warn_rep), .i_motor_lock_response_select(lck_sel),
    .i_lock_en(lock_en), .i_clear_fault_bit(clr), .o_fault_pin_n(pin_n),
    .o_bridge(bridge), .o_charge_pump_en(cp_en), .o_buck_hiz(buck_hiz),
    .o_reset_req(rst_req), .o_flags(flags)
  );

  mdfp_host_model i_host (
    .i_clk(i_clk), .i_req(clr_req), .i_delay(host_dly),
    .o_clear_fault_bit(clr), .o_done(clr_done)
  );

  task automatic complete_run;
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge i_clk);
      #1;
    end
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task automatic look(input logic pin, input mdfp_pkg::mdfp_bridge_e br, input logic [16:0] ef);
    chk({31'h0, pin_n}, {31'h0, pin});
    chk({29'h0, bridge}, {29'h0, br});
    chk({15'h0, flags}, {15'h0, ef});
  endtask

  task automatic host_clear(input logic [3:0] dly);
    int n;
    n = 0;
    host_dly = dly;
    clr_req = 1'b1;
    while (clr_done !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk({31'h0, clr_done}, 32'h1);
    clr_req = 1'b0;
    cyc(2);
  endtask

  task automatic oc_case(input logic [1:0] mode);
    mdfp_pkg::mdfp_flags_s ef;
    mdfp_pkg::mdfp_bridge_e br;
    int n;
    ef = '0;
    ef.driver_fault = (mode != 2'h3);
    ef.fet_overcurrent_flag = (mode != 2'h3);
    ef.fet_flag = (mode != 2'h3) ? 6'h04 : 6'h00;
    br = mode[1] ? mdfp_pkg::BR_NORMAL : mdfp_pkg::BR_ALL_OFF;
    oc_sel = mode;
    fet_oc = 6'h04;
    n = 0;
    while (pin_n !== 1'b0 && n < 3 * DEG + 12) begin
      cyc(1);
      n++;
    end
    if (mode == 2'h0) chk(32'(n), 32'(DEG + 3));
    cyc(1);
    look(mode[1], br, ef);
    if (mode == 2'h0) begin
      // clear while the overcurrent is still present must be ignored
      host_clear(4'h0);
      look(1'b0, br, ef);
    end
    if (mode == 2'h1) begin
      fet_oc = 6'h00;
      n = 0;
      while (pin_n === 1'b0 && n < 50) begin
        cyc(1);
        n++;
      end
      chk(32'(n), 32'(ORT));
      ef.driver_fault = 1'b0;
      br = mdfp_pkg::BR_NORMAL;
    end
    fet_oc = 6'h00;
    cyc(ORT + 4);
    look(mode != 2'h0, br, ef);
    host_clear(4'h5);
    look(1'b1, mdfp_pkg::BR_NORMAL, '0);
  endtask

  task automatic code_case(input logic lk, input logic [3:0] code);
    mdfp_pkg::mdfp_flags_s ef;
    mdfp_pkg::mdfp_bridge_e br;
    logic act;
    logic pin;
    act = !(code[3] && code[0]);
    ef = '0;
    ef.controller_fault = act;
    if (lk) begin
      ef.motor_lock_flag = act;
      ef.lock_cond_flag = act ? 3'h2 : 3'h0;
    end else begin
      ef.current_limit_flag = act;
    end
    br = code[1] ? (code[0] ? mdfp_pkg::BR_LS_ON : mdfp_pkg::BR_HS_ON) :
        (code[0] ? mdfp_pkg::BR_RECIRC : mdfp_pkg::BR_ALL_OFF);
    if (code[3]) br = mdfp_pkg::BR_NORMAL;
    pin = code[3];
    lim_sel = code;
    lck_sel = code;
    if (lk) lock_c = 3'h2;
    else amp_over = 1'b1;
    cyc(DEG + 8);
    look(pin, br, ef);
    lock_c = 3'h0;
    amp_over = 1'b0;
    cyc(LRT + 10);
    if (code[3:2] == 2'h1) begin
      ef = '0;
      br = mdfp_pkg::BR_NORMAL;
      pin = 1'b1;
    end
    look(pin, br, ef);
    host_clear(code);
    look(1'b1, mdfp_pkg::BR_NORMAL, '0);
  endtask

  initial begin
    cyc(4);
    i_nrst = 1'b1;
    cyc(1);
    look(1'b1, mdfp_pkg::BR_NORMAL, '0);
    chk({29'h0, cp_en, buck_hiz, rst_req}, 32'h4);
    for (int m = 0; m < 4; m++) oc_case(2'(m));
    // a pulse one sample short of the deglitch must not trip
    oc_sel = 2'h0;
    fet_oc = 6'h01;
    cyc(DEG + 1);
    fet_oc = 6'h00;
    cyc(DEG + 6);
    look(1'b1, mdfp_pkg::BR_NORMAL, '0);
    for (int c = 0; c < 32; c++) code_case(c[4], c[3:0]);
    lck_sel = 4'h0;
    running = 1'b0;
    lock_c = 3'h2;
    cyc(6);
    look(1'b1, mdfp_pkg::BR_NORMAL, '0);
    running = 1'b1;
    lock_en = 3'h5;
    cyc(6);
    look(1'b1, mdfp_pkg::BR_NORMAL, '0);
    lock_c = 3'h0;
    lock_en = 3'h7;
    warn_rep = 1'b0;
    warn_hot = 1'b1;
    warn_cool = 1'b0;
    cyc(4);
    look(1'b1, mdfp_pkg::BR_NORMAL, '0);
    warn_rep = 1'b1;
    cyc(4);
    exp_fl = '0;
    exp_fl.die_heat_flag = 1'b1;
    exp_fl.heat_warning_flag = 1'b1;
    look(1'b0, mdfp_pkg::BR_NORMAL, exp_fl);
    host_clear(4'h0);
    warn_hot = 1'b0;
    cyc(3);
    look(1'b0, mdfp_pkg::BR_NORMAL, exp_fl);
    warn_cool = 1'b1;
    cyc(3);
    exp_fl.die_heat_flag = 1'b0;
    look(1'b1, mdfp_pkg::BR_NORMAL, exp_fl);
    host_clear(4'h3);
    look(1'b1, mdfp_pkg::BR_NORMAL, '0);
    // overcurrent, limit and warning responses disabled, lock left at latch: shutdown still acts
    oc_sel = 2'h3;
    lim_sel = 4'h9;
    warn_rep = 1'b0;
    tsd_hot = 1'b1;
    tsd_cool = 1'b0;
    cyc(4);
    exp_fl = '0;
    exp_fl.driver_fault = 1'b1;
    exp_fl.die_heat_flag = 1'b1;
    exp_fl.thermal_shutdown_flag = 1'b1;
    look(1'b0, mdfp_pkg::BR_ALL_OFF, exp_fl);
    chk({31'h0, cp_en}, 32'h0);
    tsd_hot = 1'b0;
    cyc(3);
    look(1'b0, mdfp_pkg::BR_ALL_OFF, exp_fl);
    tsd_cool = 1'b1;
    cyc(3);
    exp_fl = '0;
    exp_fl.thermal_shutdown_flag = 1'b1;
    look(1'b1, mdfp_pkg::BR_NORMAL, exp_fl);
    chk({31'h0, cp_en}, 32'h1);
    host_clear(4'h1);
    look(1'b1, mdfp_pkg::BR_NORMAL, '0);
    buck_oc = 1'b1;
    cyc(DEG + 6);
    buck_oc = 1'b0;
    cyc(3);
    chk({30'h0, buck_hiz, rst_req}, 32'h3);
    i_nrst = 1'b0;
    cyc(2);
    i_nrst = 1'b1;
    cyc(1);
    chk({30'h0, buck_hiz, rst_req}, 32'h0);
    complete_run();
  end

  // the whole sequence needs about two thousand cycles
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule
